/* File: inc/loader_link_if.sv */
// byte-level command link between the loader host and the device
`timescale 1ns/1ns
interface loader_link_if;
    logic req_valid;
    logic [6:0] dev_addr;
    logic [7:0] cmd;
    logic [7:0] wdata;
    logic rd;
    logic last;
    logic [7:0] rdata;
    logic rvalid;

    modport host (
        output req_valid,
        output dev_addr,
        output cmd,
        output wdata,
        output rd,
        output last,
        input rdata,
        input rvalid
    );

    modport device (
        input req_valid,
        input dev_addr,
        input cmd,
        input wdata,
        input rd,
        input last,
        output rdata,
        output rvalid
    );
endinterface

/* File: inc/loader_pkg.sv */
// constants, codes and types shared by both ends of the program loader link
package loader_pkg;

    // command codes carried in the command byte of each link request
    localparam logic [7:0] CMD_VERSION = 8'h41;
    localparam logic [7:0] CMD_CONTROL = 8'h60;
    localparam logic [7:0] CMD_DATA = 8'h61;
    localparam logic [7:0] CMD_ADDR_LO = 8'h62;
    localparam logic [7:0] CMD_ADDR_HI = 8'h63;

    // bus addresses; the default device address is arbitrary, bit 0 low
    localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h20;
    localparam logic [6:0] UPPER_ADDR_BIT = 7'h01;
    localparam logic [6:0] BROADCAST_ADDR = 7'h7F;

    // control register field positions and masks
    localparam int BIT_ACCESS = 7;
    localparam int BIT_CPU_HOLD = 6;
    localparam int BIT_CHECK_EN = 4;
    localparam int BIT_RAM_EXEC = 3;
    localparam int BIT_CHECK_SEL = 2;
    localparam int BIT_DIR = 1;
    localparam int BIT_PTR_CLR = 0;
    localparam logic [7:0] CTRL_ACCESS = 8'h80;
    localparam logic [7:0] CTRL_CPU_HOLD = 8'h40;
    localparam logic [7:0] CTRL_CHECK_EN = 8'h10;
    localparam logic [7:0] CTRL_RAM_EXEC = 8'h08;
    localparam logic [7:0] CTRL_CHECK_SEL = 8'h04;
    localparam logic [7:0] CTRL_DIR = 8'h02;
    localparam logic [7:0] CTRL_PTR_CLR = 8'h01;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] START_RESET = 16'h0000;

    // image check
    localparam logic [7:0] VERSION_RESET = 8'h00;
    localparam logic [7:0] VERSION_MIN = 8'h01;
    localparam logic [7:0] VERSION_MAX = 8'hFE;
    localparam logic [7:0] VERSION_BAD = 8'hFF;
    localparam logic [15:0] IMAGE_VERSION_LOC = 16'h0000;

    // timing at 100 MHz
    localparam int CLOCK_KHZ = 100000;
    localparam int POWER_UP_MS = 50;
    localparam int POWER_UP_CYCLES = POWER_UP_MS * CLOCK_KHZ;

    // host software register map
    localparam logic [3:0] HOST_REG_CMD = 4'h0;
    localparam logic [3:0] HOST_REG_ADDR_LO = 4'h1;
    localparam logic [3:0] HOST_REG_ADDR_HI = 4'h2;
    localparam logic [3:0] HOST_REG_DATA = 4'h3;
    localparam logic [3:0] HOST_REG_DATA_END = 4'h4;
    localparam logic [3:0] HOST_REG_READ_REQ = 4'h5;
    localparam logic [3:0] HOST_REG_STATUS = 4'h6;
    localparam logic [3:0] HOST_REG_VERSION = 4'h7;
    localparam int HOST_CMD_BCAST_BIT = 3;
    localparam int STAT_BUSY = 0;
    localparam int STAT_READY = 1;
    localparam int STAT_READ_VALID = 2;
    localparam int STAT_SAFE = 3;

    // steps of the setup sequence
    localparam logic [2:0] STEP_ADDR_LO = 3'h0;
    localparam logic [2:0] STEP_ADDR_HI = 3'h1;
    localparam logic [2:0] STEP_DIR_HIGH = 3'h2;
    localparam logic [2:0] STEP_ENTER = 3'h3;
    localparam logic [2:0] STEP_DIR_SET = 3'h4;
    localparam logic [2:0] STEP_PTR_SET = 3'h5;
    localparam logic [2:0] STEP_FIRST = 3'h0;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_PROG_WRITE = 3'h1,
        OP_PROG_READ = 3'h2,
        OP_PAR_WRITE = 3'h3,
        OP_PAR_READ = 3'h4,
        OP_RUN = 3'h5,
        OP_VERSION = 3'h6
    } op_type;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] data;
        logic rd;
        logic done;
    } link_step_type;

endpackage

/* File: logic/loader_byte_ram.sv */
// single-port byte memory with registered read data
`timescale 1ns/1ns
module loader_byte_ram #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 8
) (
    input wire logic ref_clk_in,
    input wire logic we_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    output logic [DATA_W-1:0] rdata_out
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // no reset: contents are whatever the host last loaded
    always_ff @(posedge ref_clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
        rdata_out <= mem[addr_in];
    end
endmodule

/* File: logic/loader_device.sv */
// device end: loader registers, program and check memories, image check
`timescale 1ns/1ns
// Functional notes
// - control register at command 0x60
// - bit 7 gates host memory access
// - bit 6 holds processor only
// - bit 4 enables check bits
// - bit 3 selects RAM plus ROM execution
// - bit 2 redirects data port to check memory
// - bit 1 picks write or read at 0x61
// - data port streams bytes until stop
// - bit 0 reloads pointer; host pulses it
// - 16-bit start address at 0x62, 0x63
// - data writes land from start address
// - host defers unrelated traffic while loading
// - only lower address reaches loader registers
// - broadcast address writes are accepted
// - host waits 50 ms after power-up
// - host write setup sequence
// - host read setup keeps direction high
// - safe mode accepts the same setup
// - check memory setup adds bit 2
// - host run sequence sets bits 4, 3
// - image check finishes within 1 ms
// - valid image reports version 0x01-0xFE
// - invalid image: 0xFF, exec off, safe
module loader_device import loader_pkg::*; #(
    parameter int ADDR_W = 10,
    parameter logic [6:0] DEV_ADDR = DEFAULT_DEV_ADDR
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    loader_link_if.device lnk,
    output logic cpu_hold_out,
    output logic ram_exec_out,
    output logic check_enable_out,
    output logic safe_mode_out,
    output logic [7:0] version_out
);
    typedef enum {CHK_IDLE, CHK_READ, CHK_DECIDE} chk_state_type;

    chk_state_type chk_reg, chk_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [15:0] start_reg, start_next;
    logic [15:0] ptr_reg, ptr_next;
    logic [7:0] version_reg, version_next;
    logic safe_reg, safe_next;
    logic [7:0] reg_rdata_reg, reg_rdata_next;
    logic rvalid_reg, rvalid_next;
    logic from_mem_reg, from_mem_next;
    logic from_check_reg, from_check_next;
    logic addr_hit, wr_hit, rd_hit, data_wr, data_rd, check_start;
    logic prog_we, par_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0] prog_q, par_q;
    logic image_ok;

    // upper address never matches, so it cannot touch memory
    // shared-address reads get no answer: several devices would collide
    assign addr_hit = lnk.req_valid &&
        (lnk.dev_addr == DEV_ADDR ||
         (lnk.dev_addr == BROADCAST_ADDR && !lnk.rd));
    assign wr_hit = addr_hit && !lnk.rd;
    assign rd_hit = addr_hit && lnk.rd;
    assign data_wr = wr_hit && lnk.cmd == CMD_DATA &&
        ctrl_reg[BIT_ACCESS] && !ctrl_reg[BIT_DIR];
    assign data_rd = rd_hit && lnk.cmd == CMD_DATA &&
        ctrl_reg[BIT_ACCESS] && ctrl_reg[BIT_DIR];
    assign prog_we = data_wr && !ctrl_reg[BIT_CHECK_SEL];
    assign par_we = data_wr && ctrl_reg[BIT_CHECK_SEL];
    // check starts when the processor is released with RAM execution on
    assign check_start = wr_hit && lnk.cmd == CMD_CONTROL &&
        ctrl_reg[BIT_CPU_HOLD] && !lnk.wdata[BIT_CPU_HOLD] &&
        lnk.wdata[BIT_RAM_EXEC];
    // the check bit must equal the xor of the version byte
    assign image_ok = prog_q >= VERSION_MIN && prog_q <= VERSION_MAX &&
        (!ctrl_reg[BIT_CHECK_EN] || par_q[0] == ^prog_q);

    loader_byte_ram #(.ADDR_W(ADDR_W), .DATA_W(8)) prog_ram (
        .ref_clk_in(ref_clk_in),
        .we_in(prog_we),
        .addr_in(mem_addr),
        .wdata_in(lnk.wdata),
        .rdata_out(prog_q)
    );

    loader_byte_ram #(.ADDR_W(ADDR_W), .DATA_W(8)) check_ram (
        .ref_clk_in(ref_clk_in),
        .we_in(par_we),
        .addr_in(mem_addr),
        .wdata_in(lnk.wdata),
        .rdata_out(par_q)
    );

    always_comb begin
        ctrl_next = ctrl_reg;
        start_next = start_reg;
        ptr_next = ptr_reg;
        version_next = version_reg;
        safe_next = safe_reg;
        chk_next = chk_reg;
        reg_rdata_next = 8'h00;
        rvalid_next = 1'b0;
        from_mem_next = 1'b0;
        from_check_next = from_check_reg;
        mem_addr = ptr_reg[ADDR_W-1:0];
        if (wr_hit) begin
            if (lnk.cmd == CMD_CONTROL) begin
                ctrl_next = lnk.wdata;
            end else if (lnk.cmd == CMD_ADDR_LO) begin
                start_next[7:0] = lnk.wdata;
            end else if (lnk.cmd == CMD_ADDR_HI) begin
                start_next[15:8] = lnk.wdata;
            end
        end
        // every read to our address is answered, refused ones with zero
        if (rd_hit) begin
            rvalid_next = 1'b1;
            if (lnk.cmd == CMD_CONTROL) begin
                reg_rdata_next = ctrl_reg;
            end else if (lnk.cmd == CMD_ADDR_LO) begin
                reg_rdata_next = start_reg[7:0];
            end else if (lnk.cmd == CMD_ADDR_HI) begin
                reg_rdata_next = start_reg[15:8];
            end else if (lnk.cmd == CMD_VERSION) begin
                reg_rdata_next = version_reg;
            end else if (data_rd) begin
                from_mem_next = 1'b1;
                from_check_next = ctrl_reg[BIT_CHECK_SEL];
            end
        end
        // a held clear keeps the pointer parked on the start address
        // only the low ADDR_W pointer bits reach the memories
        if (ctrl_reg[BIT_PTR_CLR]) begin
            ptr_next = start_reg;
        end else if (data_wr || data_rd) begin
            ptr_next = ptr_reg + 16'h0001;
        end
        case (chk_reg)
            CHK_IDLE: begin
                if (check_start) begin
                    chk_next = CHK_READ;
                end
            end
            CHK_READ: begin
                // link traffic in this cycle would see location 0
                mem_addr = IMAGE_VERSION_LOC[ADDR_W-1:0];
                chk_next = CHK_DECIDE;
            end
            default: begin
                chk_next = CHK_IDLE;
                if (image_ok) begin
                    version_next = prog_q;
                    safe_next = 1'b0;
                end else begin
                    version_next = VERSION_BAD;
                    ctrl_next[BIT_RAM_EXEC] = 1'b0;
                    safe_next = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            chk_reg <= CHK_IDLE;
            ctrl_reg <= CTRL_RESET;
            start_reg <= START_RESET;
            ptr_reg <= START_RESET;
            version_reg <= VERSION_RESET;
            safe_reg <= 1'b0;
            reg_rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
            from_mem_reg <= 1'b0;
            from_check_reg <= 1'b0;
        end else begin
            chk_reg <= chk_next;
            ctrl_reg <= ctrl_next;
            start_reg <= start_next;
            ptr_reg <= ptr_next;
            version_reg <= version_next;
            safe_reg <= safe_next;
            reg_rdata_reg <= reg_rdata_next;
            rvalid_reg <= rvalid_next;
            from_mem_reg <= from_mem_next;
            from_check_reg <= from_check_next;
        end
    end

    // memory data comes straight from the ram output flops
    always_comb begin
        if (!from_mem_reg) begin
            lnk.rdata = reg_rdata_reg;
        end else if (from_check_reg) begin
            lnk.rdata = par_q;
        end else begin
            lnk.rdata = prog_q;
        end
    end
    assign lnk.rvalid = rvalid_reg;
    assign cpu_hold_out = ctrl_reg[BIT_CPU_HOLD];
    assign ram_exec_out = ctrl_reg[BIT_RAM_EXEC];
    assign check_enable_out = ctrl_reg[BIT_CHECK_EN];
    assign safe_mode_out = safe_reg;
    assign version_out = version_reg;
endmodule

/* File: logic/loader_host.sv */
// host end: sequences loader setup, data transfer and run over the link
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
module loader_host import loader_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = DEFAULT_DEV_ADDR,
    parameter int POWER_UP_WAIT = POWER_UP_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    loader_link_if.host lnk
);
    localparam int CNT_W = $clog2(POWER_UP_WAIT + 1);
    typedef enum {H_POWERUP, H_IDLE, H_SEQ, H_WAIT_READ} host_state_type;

    function automatic link_step_type seq_step(op_type op,
            logic [2:0] step, logic [15:0] start);
        link_step_type s;
        logic [7:0] base;
        logic [7:0] dir;
        base = CTRL_ACCESS | CTRL_CPU_HOLD |
            ((op == OP_PAR_WRITE || op == OP_PAR_READ) ?
             CTRL_CHECK_SEL : 8'h00);
        dir = (op == OP_PROG_READ || op == OP_PAR_READ) ?
            CTRL_DIR : 8'h00;
        s = '{cmd: CMD_CONTROL, data: 8'h00, rd: 1'b0, done: 1'b0};
        if (op == OP_RUN) begin
            if (step == STEP_FIRST) begin
                s.data = CTRL_ACCESS | CTRL_CPU_HOLD | CTRL_CHECK_SEL;
            end else begin
                s.data = CTRL_CHECK_EN | CTRL_RAM_EXEC;
                s.done = 1'b1;
            end
        end else if (op == OP_VERSION) begin
            s.cmd = CMD_VERSION;
            s.rd = 1'b1;
            s.done = 1'b1;
        end else if (step == STEP_ADDR_LO) begin
            s.cmd = CMD_ADDR_LO;
            s.data = start[7:0];
        end else if (step == STEP_ADDR_HI) begin
            s.cmd = CMD_ADDR_HI;
            s.data = start[15:8];
        end else if (step == STEP_DIR_HIGH) begin
            s.data = CTRL_DIR;
        end else if (step == STEP_ENTER) begin
            s.data = base | CTRL_DIR;
        end else if (step == STEP_DIR_SET) begin
            s.data = base | dir;
        end else if (step == STEP_PTR_SET) begin
            s.data = base | dir | CTRL_PTR_CLR;
        end else begin
            s.data = base | dir;
            s.done = 1'b1;
        end
        return s;
    endfunction

    host_state_type state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    op_type op_reg, op_next;
    logic [2:0] step_reg, step_next;
    logic bcast_reg, bcast_next;
    logic [15:0] start_reg, start_next;
    logic [7:0] read_byte_reg, read_byte_next;
    logic read_valid_reg, read_valid_next;
    logic [7:0] version_reg, version_next;
    logic [7:0] rdata_reg, rdata_next;
    logic req_reg, req_next;
    logic [6:0] dev_reg, dev_next;
    logic [7:0] cmd_reg, cmd_next;
    logic [7:0] wd_reg, wd_next;
    logic rdq_reg, rdq_next;
    logic last_reg, last_next;
    link_step_type cur;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        op_next = op_reg;
        step_next = step_reg;
        bcast_next = bcast_reg;
        start_next = start_reg;
        read_byte_next = read_byte_reg;
        read_valid_next = read_valid_reg;
        version_next = version_reg;
        rdata_next = 8'h00;
        req_next = 1'b0;
        dev_next = dev_reg;
        cmd_next = cmd_reg;
        wd_next = wd_reg;
        rdq_next = 1'b0;
        last_next = 1'b0;
        cur = seq_step(op_reg, step_reg, start_reg);
        if (rd_in) begin
            if (addr_in == HOST_REG_ADDR_LO) begin
                rdata_next = start_reg[7:0];
            end else if (addr_in == HOST_REG_ADDR_HI) begin
                rdata_next = start_reg[15:8];
            end else if (addr_in == HOST_REG_DATA) begin
                rdata_next = read_byte_reg;
                read_valid_next = 1'b0;
            end else if (addr_in == HOST_REG_STATUS) begin
                rdata_next[STAT_BUSY] = state_reg != H_IDLE;
                rdata_next[STAT_READY] = state_reg != H_POWERUP;
                rdata_next[STAT_READ_VALID] = read_valid_reg;
                rdata_next[STAT_SAFE] = version_reg == VERSION_BAD;
            end else if (addr_in == HOST_REG_VERSION) begin
                rdata_next = version_reg;
            end
        end
        case (state_reg)
            H_POWERUP: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == CNT_W'(POWER_UP_WAIT - 1)) begin
                    state_next = H_IDLE;
                end
            end
            H_IDLE: begin
                // only loader traffic is ever generated here
                if (wr_in && addr_in == HOST_REG_CMD &&
                        wdata_in[2:0] != OP_NONE &&
                        wdata_in[2:0] <= OP_VERSION) begin
                    op_next = op_type'(wdata_in[2:0]);
                    bcast_next = wdata_in[HOST_CMD_BCAST_BIT];
                    step_next = STEP_FIRST;
                    state_next = H_SEQ;
                end else if (wr_in && addr_in == HOST_REG_ADDR_LO) begin
                    start_next[7:0] = wdata_in;
                end else if (wr_in && addr_in == HOST_REG_ADDR_HI) begin
                    start_next[15:8] = wdata_in;
                end else if (wr_in && (addr_in == HOST_REG_DATA ||
                        addr_in == HOST_REG_DATA_END)) begin
                    req_next = 1'b1;
                    dev_next = bcast_reg ? BROADCAST_ADDR : DEV_ADDR;
                    cmd_next = CMD_DATA;
                    wd_next = wdata_in;
                    last_next = addr_in == HOST_REG_DATA_END;
                end else if (wr_in && addr_in == HOST_REG_READ_REQ) begin
                    req_next = 1'b1;
                    dev_next = DEV_ADDR;
                    cmd_next = CMD_DATA;
                    rdq_next = 1'b1;
                    last_next = wdata_in[0];
                    op_next = OP_NONE;
                    state_next = H_WAIT_READ;
                end
            end
            H_SEQ: begin
                req_next = 1'b1;
                // reads never go to the broadcast address
                dev_next = (bcast_reg && !cur.rd) ?
                    BROADCAST_ADDR : DEV_ADDR;
                cmd_next = cur.cmd;
                wd_next = cur.data;
                rdq_next = cur.rd;
                last_next = 1'b1;
                step_next = step_reg + 3'h1;
                if (cur.rd) begin
                    state_next = H_WAIT_READ;
                end else if (cur.done) begin
                    state_next = H_IDLE;
                end
            end
            default: begin
                if (lnk.rvalid) begin
                    state_next = H_IDLE;
                    if (op_reg == OP_VERSION) begin
                        version_next = lnk.rdata;
                    end else begin
                        read_byte_next = lnk.rdata;
                        read_valid_next = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            state_reg <= H_POWERUP;
            cnt_reg <= '0;
            op_reg <= OP_NONE;
            step_reg <= STEP_FIRST;
            bcast_reg <= 1'b0;
            start_reg <= START_RESET;
            read_byte_reg <= 8'h00;
            read_valid_reg <= 1'b0;
            version_reg <= VERSION_RESET;
            rdata_reg <= 8'h00;
            req_reg <= 1'b0;
            dev_reg <= DEV_ADDR;
            cmd_reg <= 8'h00;
            wd_reg <= 8'h00;
            rdq_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            op_reg <= op_next;
            step_reg <= step_next;
            bcast_reg <= bcast_next;
            start_reg <= start_next;
            read_byte_reg <= read_byte_next;
            read_valid_reg <= read_valid_next;
            version_reg <= version_next;
            rdata_reg <= rdata_next;
            req_reg <= req_next;
            dev_reg <= dev_next;
            cmd_reg <= cmd_next;
            wd_reg <= wd_next;
            rdq_reg <= rdq_next;
            last_reg <= last_next;
        end
    end

    assign rdata_out = rdata_reg;
    assign lnk.req_valid = req_reg;
    assign lnk.dev_addr = dev_reg;
    assign lnk.cmd = cmd_reg;
    assign lnk.wdata = wd_reg;
    assign lnk.rd = rdq_reg;
    assign lnk.last = last_reg;
endmodule

/* File: verification/loader_link_checker.sv */
// assertions on the link between loader host and loader device
`timescale 1ns/1ns
module loader_link_checker import loader_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = DEFAULT_DEV_ADDR
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic req_valid,
    input wire logic [6:0] dev_addr,
    input wire logic [7:0] cmd,
    input wire logic [7:0] wdata,
    input wire logic rd,
    input wire logic last,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic own_rd;
    logic ctrl_wr;
    logic closed_rd;
    assign own_rd = req_valid && rd && dev_addr == DEV_ADDR;
    assign ctrl_wr = req_valid && !rd && cmd == CMD_CONTROL;
    assign closed_rd = own_rd && cmd == CMD_DATA
        && !(ctrl_reg[BIT_ACCESS] && ctrl_reg[BIT_DIR]);
    // mirror of the control byte; the internal clear of bit 3 is not
    // tracked, only access and direction bits are relied on
    always_comb begin
        ctrl_next = ctrl_wr ? wdata : ctrl_reg;
    end
    always_ff @(posedge ref_clk_in) begin
        ctrl_reg <= resetn_in ? ctrl_next : CTRL_RESET;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    a_read_answer: assert property (own_rd |=> rvalid)
        else $error("read left unanswered");
    a_no_stray: assert property (rvalid |-> $past(own_rd))
        else $error("answer without read");
    a_closed_read: assert property (closed_rd |=> rdata == 8'h00)
        else $error("blocked read returned data");
    a_ptr_release: assert property (ctrl_wr && wdata[BIT_PTR_CLR] |=>
        ctrl_wr && !wdata[BIT_PTR_CLR])
        else $error("pointer clear not released");
    a_setup_raise: assert property (ctrl_wr && wdata[BIT_ACCESS] &&
        !ctrl_reg[BIT_ACCESS] |-> wdata[BIT_DIR] && wdata[5:3] == 3'h0)
        else $error("access raised out of order");
    a_addr_pair: assert property (req_valid && cmd == CMD_ADDR_HI |->
        $past(req_valid && cmd == CMD_ADDR_LO))
        else $error("high start byte without low byte");
    a_read_own: assert property (req_valid && rd |->
        dev_addr == DEV_ADDR)
        else $error("read sent to shared address");
    a_stop_data: assert property ((last |-> req_valid) and
        (req_valid && cmd != CMD_DATA |-> last))
        else $error("stop missing or outside a request");
    a_loader_only: assert property (req_valid |->
        dev_addr != (DEV_ADDR | UPPER_ADDR_BIT) &&
        (cmd == CMD_CONTROL || cmd == CMD_DATA || cmd == CMD_VERSION ||
        cmd == CMD_ADDR_LO || cmd == CMD_ADDR_HI))
        else $error("link request outside the loader set");
    c_data_wr: cover property (req_valid && !rd && cmd == CMD_DATA);
    c_closed: cover property (closed_rd);
    c_bcast: cover property (req_valid && dev_addr == BROADCAST_ADDR);
endmodule

/* File: verification/testbench.sv */
// bench: loader host user port drives the device over the link
`timescale 1ns/1ns
module testbench import loader_pkg::*;;
    logic ref_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out, version_out, rv, outs;
    logic cpu_hold_out, ram_exec_out, check_enable_out, safe_mode_out;
    int fails = 0;
    int cmp_count = 0;
    assign outs = {cpu_hold_out, ram_exec_out, check_enable_out,
        safe_mode_out, 4'h0};
    loader_link_if lnk ();
    // short power-up wait keeps the run brief
    loader_host #(.POWER_UP_WAIT(16)) loader_host_i (
        .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .lnk(lnk));
    loader_device loader_device_i (.ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in), .lnk(lnk), .cpu_hold_out(cpu_hold_out),
        .ram_exec_out(ram_exec_out), .check_enable_out(check_enable_out),
        .safe_mode_out(safe_mode_out), .version_out(version_out));
    loader_link_checker loader_link_checker_i (.ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in), .req_valid(lnk.req_valid),
        .dev_addr(lnk.dev_addr), .cmd(lnk.cmd), .wdata(lnk.wdata),
        .rd(lnk.rd), .last(lnk.last), .rdata(lnk.rdata),
        .rvalid(lnk.rvalid));
    initial forever #5 ref_clk_in = ~ref_clk_in;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1 rv = rdata_out;
    endtask
    // the next command is ignored while busy, so poll before returning
    task automatic op(input logic [7:0] c);
        wr(HOST_REG_CMD, c);
        rv = 8'h01;
        for (int i = 0; i < 40 && rv[STAT_BUSY]; i++) rd(HOST_REG_STATUS);
        repeat (4) @(posedge ref_clk_in);
    endtask
    task automatic rdm();
        wr(HOST_REG_READ_REQ, 8'h00);
        repeat (3) @(posedge ref_clk_in);
        rd(HOST_REG_DATA);
    endtask
    task automatic t_load();
        wr(HOST_REG_ADDR_LO, 8'h00);
        wr(HOST_REG_ADDR_HI, 8'h00);
        op(8'h01);
        chk(outs, 8'h80);
        wr(HOST_REG_DATA, 8'h05);
        wr(HOST_REG_DATA, 8'hA5);
        wr(HOST_REG_DATA_END, 8'h3C);
        rdm();
        chk(rv, 8'h00);
        op(8'h02);
        rdm();
        chk(rv, 8'h05);
        rdm();
        chk(rv, 8'hA5);
        rdm();
        chk(rv, 8'h3C);
        wr(HOST_REG_ADDR_LO, 8'h02);
        wr(HOST_REG_ADDR_HI, 8'h04);
        op(8'h02);
        rdm();
        chk(rv, 8'h3C);
        $display("test load done");
    endtask
    task automatic t_run(input logic [7:0] v, input logic [7:0] p);
        wr(HOST_REG_ADDR_LO, 8'h00);
        wr(HOST_REG_ADDR_HI, 8'h00);
        op(8'h09);
        wr(HOST_REG_DATA_END, v);
        op(8'h0B);
        wr(HOST_REG_DATA_END, p);
        op(8'h04);
        rdm();
        chk(rv & 8'h01, p);
        op(8'h05);
        chk(outs, (v == VERSION_BAD) ? 8'h30 : 8'h60);
        op(8'h06);
        rd(HOST_REG_VERSION);
        chk(rv, v);
        chk(version_out, v);
        rd(HOST_REG_STATUS);
        chk(rv & 8'h08, (v == VERSION_BAD) ? 8'h08 : 8'h00);
        $display("test run %h done", v);
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        chk(outs, 8'h00);
        chk(version_out, VERSION_RESET);
        repeat (20) @(posedge ref_clk_in);
        rd(HOST_REG_STATUS);
        chk(rv & 8'h0B, 8'h02);
        $display("test reset done");
        t_load();
        t_run(8'h05, 8'h00);
        t_run(8'hFF, 8'h00);
        t_run(8'h07, 8'h01);
        test_done();
    end
    initial begin
        #200000;
        fails++;
        test_done();
    end
endmodule
